// >>> dv/osp_host_model.sv
// Host model: a management-bus master issuing paged command bytes.
// Assumes the command port answers one cycle after the request is taken.
`timescale 1ns/100ps
module osp_host_model (
  input wire logic clock_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic [7:0] cmd_page_o,
  output logic [7:0] cmd_wdata_o,
  input wire logic cmd_ack_i,
  input wire logic cmd_err_i,
  input wire logic [7:0] cmd_rdata_i
);
  // ==================================================================
  // Idle values at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_page_o = 8'h00;
    cmd_wdata_o = 8'h00;
  end

  // One request per call; callers only touch sequencing settings while idle
  // Rank bytes with no staging are given equal values by the caller
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] page,
                      input logic [7:0] wd, output logic ack, output logic err,
                      output logic [7:0] rd);
    @(negedge clock_i);
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_code_o = code;
    cmd_page_o = page;
    cmd_wdata_o = wd;
    @(negedge clock_i);
    ack = cmd_ack_i;
    err = cmd_err_i;
    rd = cmd_rdata_i;
    cmd_valid_o = 1'b0;
    // Scramble qualifiers so nothing relies on stale values
    cmd_code_o = ~cmd_code_o;
    cmd_page_o = ~cmd_page_o;
    cmd_wdata_o = ~cmd_wdata_o;
  endtask
endmodule

// >>> dv/osp_sequencer_tb.sv
// Self-checking bench for the output sequencer and phase configuration.
// Assumes the host model drives commands; bench drives all other inputs.
`timescale 1ns/100ps
module osp_sequencer_tb;
  import osp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, load = 1'b0, seq_on = 1'b0;
  logic [3:0] nvm_cond = 4'h0, pg = 4'h0;
  logic [27:0] nvm_timing = 28'h0;
  logic [1:0] shr = 2'h0;
  logic valid, wr, ack, err;
  logic [7:0] code, page, wdata, rdata, clk_div;
  logic [3:0] store_cond, out_en, continuous_conduction_sel;
  logic [27:0] store_timing;
  logic busy;
  logic [23:0] phase;
  int error_cnt = 0, tests_run = 0, cyc = 0;

  // ==================================================================
  // Clock, timeout and instances
  always #25 clk = ~clk;
  // Ceiling well above the 160 or so cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  osp_host_model host (.clock_i(clk), .cmd_valid_o(valid), .cmd_write_o(wr),
    .cmd_code_o(code), .cmd_page_o(page), .cmd_wdata_o(wdata), .cmd_ack_i(ack),
    .cmd_err_i(err), .cmd_rdata_i(rdata));
  osp_sequencer dut (.clock_i(clk), .reset_n_i(rst_n), .cmd_valid_i(valid),
    .cmd_write_i(wr), .cmd_code_i(code), .cmd_page_i(page), .cmd_wdata_i(wdata),
    .cmd_ack_o(ack), .cmd_err_o(err), .cmd_rdata_o(rdata), .nvm_load_i(load),
    .nvm_cond_i(nvm_cond), .nvm_timing_i(nvm_timing), .store_cond_o(store_cond),
    .store_timing_o(store_timing), .seq_on_i(seq_on), .power_good_i(pg),
    .share_detect_i(shr), .out_enable_o(out_en), .seq_busy_o(busy), .ccm_o(continuous_conduction_sel),
    .clk_div_o(clk_div), .phase_o(phase));

  // ==================================================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Every request must be answered; reads compare the returned byte
  task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] p,
                     input logic [7:0] d, input logic e_err, input logic [7:0] e_rd);
    logic a, e;
    logic [7:0] r;
    host.xfer(w, c, p, d, a, e, r);
    chk(a, 1'b1);
    chk(e, e_err);
    if (!w) chk(r, e_rd);
  endtask
  // Bounded wait for an enable pattern; a leftover mismatch is reported
  task automatic wait_en(input logic [3:0] exp);
    int n;
    n = 0;
    while (out_en !== exp && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(out_en, exp);
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_reset_values();
    cmd(0, OSP_CMD_SEQ_SETUP, 8'h00, 8'h00, 0, 8'h00);
    for (int p = 0; p < 4; p++) cmd(0, OSP_CMD_SEQ_RANK, p[7:0], 8'h00, 0, 8'h00);
    cmd(0, OSP_CMD_TIMING_SETUP, 8'h01, 8'h00, 0, 8'h08);
    cmd(0, OSP_CMD_TIMING_SETUP, 8'h02, 8'h00, 0, 8'h04);
    cmd(0, OSP_CMD_TIMING_SETUP, 8'h03, 8'h00, 0, 8'h0C);
    cmd(0, OSP_CMD_COND_SETUP, 8'h00, 8'h00, 0, 8'h00);
    chk(phase, {6'd3, 6'd1, 6'd2, 6'd0});
    chk(clk_div, 8'h00);
    cmd(0, OSP_CMD_SEQ_RANK, 8'h04, 8'h00, 1, 8'h00);
    // Unknown codes are accepted silently, so the refused write goes to a bad page instead
    cmd(1, OSP_CMD_SEQ_RANK, 8'h04, 8'h55, 1, 8'h00);
    cmd(0, OSP_CMD_SEQ_RANK, 8'h00, 8'h00, 0, 8'h00);
    $display("test reset_values done");
  endtask

  task automatic t_readback();
    cmd(1, OSP_CMD_SEQ_SETUP, 8'h00, 8'hFF, 0, 8'h00);
    cmd(0, OSP_CMD_SEQ_SETUP, 8'h05, 8'h00, 0, 8'h01);
    cmd(1, OSP_CMD_SEQ_RANK, 8'h02, 8'hFF, 0, 8'h00);
    cmd(0, OSP_CMD_SEQ_RANK, 8'h02, 8'h00, 0, 8'h0F);
    cmd(0, OSP_CMD_SEQ_RANK, 8'h01, 8'h00, 0, 8'h00);
    cmd(1, OSP_CMD_SEQ_RANK, 8'h02, 8'h00, 0, 8'h00);
    $display("test readback done");
  endtask

  task automatic t_staged();
    cmd(1, OSP_CMD_SEQ_SETUP, 8'h00, 8'h00, 0, 8'h00);
    // Start rank i, stop rank 3-i for output i
    for (int i = 0; i < 4; i++) cmd(1, OSP_CMD_SEQ_RANK, i[7:0], {4'h0, 2'(3 - i), 2'(i)}, 0, 0);
    @(negedge clk);
    seq_on = 1'b1;
    wait_en(4'b0001);
    repeat (10) @(negedge clk);
    chk(out_en, 4'b0001);
    pg = 4'b0001;
    wait_en(4'b0011);
    pg = 4'b0011;
    wait_en(4'b0111);
    pg = 4'b0111;
    wait_en(4'b1111);
    pg = 4'b1111;
    repeat (8) @(negedge clk);
    chk(busy, 1'b0);
    seq_on = 1'b0;
    wait_en(4'b0111);
    @(negedge clk);
    chk(out_en, 4'b0011);
    @(negedge clk);
    chk(out_en, 4'b0001);
    @(negedge clk);
    chk(out_en, 4'b0000);
    repeat (2) @(negedge clk);
    chk(busy, 1'b0);
    pg = 4'h0;
    $display("test staged done");
  endtask

  task automatic t_equal();
    int bad;
    bad = 0;
    cmd(1, OSP_CMD_SEQ_SETUP, 8'h00, 8'h01, 0, 8'h00);
    for (int i = 0; i < 4; i++) cmd(1, OSP_CMD_SEQ_RANK, i[7:0], 8'h0A, 0, 0);
    @(negedge clk);
    seq_on = 1'b1;
    // Outputs of one rank may never be seen partly on
    repeat (12) begin
      @(negedge clk);
      if (out_en !== 4'h0 && out_en !== 4'hF) bad++;
    end
    chk(out_en, 4'hF);
    seq_on = 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (out_en !== 4'h0 && out_en !== 4'hF) bad++;
    end
    chk(out_en, 4'h0);
    chk(bad, 0);
    $display("test equal_ranks done");
  endtask

  task automatic t_reload_share();
    cmd(1, OSP_CMD_COND_SETUP, 8'h00, 8'h01, 0, 8'h00);
    cmd(1, OSP_CMD_TIMING_SETUP, 8'h03, 8'h7F, 0, 8'h00);
    chk(store_cond[0], 1'b1);
    chk(store_timing[27:21], 7'h7F);
    chk(continuous_conduction_sel, 4'h0);
    chk(phase[23:18], 6'd3);
    cmd(0, OSP_CMD_COND_SETUP, 8'h00, 8'h00, 0, 8'h00);
    nvm_cond = 4'b0101;
    // Output 2 gets divider code 10 and phase 0, so all four divider codes are seen
    nvm_timing = {7'h7C, 7'h02, 7'h7F, 7'h15};
    @(negedge clk);
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    @(negedge clk);
    chk(continuous_conduction_sel, 4'b0101);
    chk(clk_div, 8'h2D);
    chk(phase, {6'd31, 6'd0, 6'd31, 6'd5});
    cmd(0, OSP_CMD_TIMING_SETUP, 8'h00, 8'h00, 0, 8'h15);
    cmd(0, OSP_CMD_COND_SETUP, 8'h01, 8'h00, 0, 8'h00);
    shr = 2'b01;
    repeat (4) @(negedge clk);
    cmd(0, OSP_CMD_COND_SETUP, 8'h00, 8'h00, 0, 8'h03);
    cmd(0, OSP_CMD_COND_SETUP, 8'h01, 8'h00, 1, 8'h00);
    cmd(1, OSP_CMD_TIMING_SETUP, 8'h01, 8'h00, 1, 8'h00);
    chk(clk_div[3:2], 2'b01);
    chk(continuous_conduction_sel[1], 1'b1);
    chk(phase[11:6], 6'd9);
    chk(phase[17:12], 6'd0);
    shr = 2'b00;
    $display("test reload_share done");
  endtask

  // ==================================================================
  // Closing report
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence: reset held 20 cycles, released at a falling edge
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset_values();
    t_readback();
    t_staged();
    t_equal();
    t_reload_share();
    test_done();
  end
endmodule

// >>> hw/osp_sequencer.sv
// Output sequencing and phase configuration for four switching outputs.
// Assumes a same-clock paged command port from the management-bus front end,
// a nonvolatile image loaded by a one-cycle load pulse, and asynchronous
// power-good and share-detect levels from the analog stages.
// Notes on behaviour
// [R01] With checking on, an output waits for power good of the prior rank.
// [R02] Wait bit is bit 0 of setup byte; 0 checks, 1 ignores; rest zero.
// [R03] First-rank outputs start without any power-good dependency.
// [R04] The wait setting is global, not paged.
// [R05] Start rank bits 1:0, stop rank bits 3:2; 00 first, 11 last; reset 00.
// [R06] Outputs of equal rank start or stop together in one step.
// [R07] Host should set equal ranks everywhere when no staging is wanted.
// [R08] Host should not change sequencing settings during a sequence.
// [R09] Rank byte is paged, valid for pages 0 to 3.
// [R10] Conduction bit 0: 1 forced continuous, 0 mixed conduction.
// [R11] Conduction bit 1 reads the share flag, visible on master pages only.
// [R12] Pairs 0/1 and 2/3; shared slave page invalid, slave follows master.
// [R13] Shared slave switches half a period after its master.
// [R14] Conduction and timing writes apply only after storage reload.
// [R15] Divider bits 1:0 divide the oscillator by 1, 2, 4 or 8.
// [R16] Phase bits 6:2 delay start by quarter-oscillator periods, 0 to 31.
// [R17] Default phase codes per page: 00000, 00010, 00001, 00011.
// [R18] Next rank only after current rank is commanded and good if checked.
`timescale 1ns/100ps
module osp_sequencer
  import osp_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] cmd_page_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic cmd_ack_o,
  output logic cmd_err_o,
  output logic [7:0] cmd_rdata_o,
  input wire logic nvm_load_i,
  input wire logic [3:0] nvm_cond_i,
  input wire logic [27:0] nvm_timing_i,
  output logic [3:0] store_cond_o,
  output logic [27:0] store_timing_o,
  input wire logic seq_on_i,
  input wire logic [3:0] power_good_i,
  input wire logic [1:0] share_detect_i,
  output logic [3:0] out_enable_o,
  output logic seq_busy_o,
  output logic [3:0] ccm_o,
  output logic [7:0] clk_div_o,
  output logic [23:0] phase_o
);
  // ==================================================================
  // Decoding helpers
  function automatic logic [1:0] rank_field(input logic [3:0] r, input int lsb);
    rank_field = r[lsb +: 2];
  endfunction

  // Page is reachable: global byte always, others in range and not a shared slave
  function automatic logic page_ok(input logic [7:0] code, input logic [7:0] page,
                                   input logic [1:0] shr);
    if (code == OSP_CMD_SEQ_SETUP) begin
      page_ok = 1'b1;
    end else begin
      page_ok = (page <= OSP_PAGE_LAST) && !(page[0] && shr[page[1]]);
    end
  endfunction

  function automatic logic [4:0] phase_default(input int idx);
    case (idx)
      0: phase_default = OSP_PHASE_RST0;
      1: phase_default = OSP_PHASE_RST1;
      2: phase_default = OSP_PHASE_RST2;
      default: phase_default = OSP_PHASE_RST3;
    endcase
  endfunction

  // ==================================================================
  // Synchronisers for analog levels
  logic [3:0] pg_meta_reg;
  logic [3:0] pg_sync_reg;
  logic [1:0] shr_meta_reg;
  logic [1:0] shr_sync_reg;

  // Two flops each; the first stage feeds only the second
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pg_meta_reg <= 4'h0;
      pg_sync_reg <= 4'h0;
      shr_meta_reg <= 2'h0;
      shr_sync_reg <= 2'h0;
    end else begin
      pg_meta_reg <= power_good_i;
      pg_sync_reg <= pg_meta_reg;
      shr_meta_reg <= share_detect_i;
      shr_sync_reg <= shr_meta_reg;
    end
  end

  // ==================================================================
  // Setting storage
  logic wait_ignore_reg;
  logic [3:0] rank_reg [OSP_OUTPUTS];
  logic [OSP_OUTPUTS-1:0] pend_cond_reg;
  logic [OSP_TIMING_W-1:0] pend_timing_reg [OSP_OUTPUTS];
  logic [OSP_OUTPUTS-1:0] act_cond_reg;
  logic [OSP_TIMING_W-1:0] act_timing_reg [OSP_OUTPUTS];
  logic cmd_hit;
  logic [1:0] pg_idx;

  assign cmd_hit = cmd_valid_i && page_ok(cmd_code_i, cmd_page_i, shr_sync_reg); // [R09] [R12]
  assign pg_idx = cmd_page_i[1:0];

  // Global wait bit, one copy for every switcher
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_ignore_reg <= OSP_WAIT_RST; // [R02]
    end else if (cmd_hit && cmd_write_i && cmd_code_i == OSP_CMD_SEQ_SETUP) begin
      wait_ignore_reg <= cmd_wdata_i[OSP_WAIT_BIT]; // [R02] [R04]
    end
  end

  // Paged rank bytes; changing them mid-sequence is the host's hazard
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < OSP_OUTPUTS; i++) begin
        rank_reg[i] <= OSP_RANK_RST; // [R05]
      end
    end else if (cmd_hit && cmd_write_i && cmd_code_i == OSP_CMD_SEQ_RANK) begin
      rank_reg[pg_idx] <= cmd_wdata_i[OSP_RANK_W-1:0]; // [R05] [R09]
    end
  end

  // Written values wait here for storage; they never steer the switchers
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_cond_reg <= '0;
      for (int i = 0; i < OSP_OUTPUTS; i++) begin
        pend_timing_reg[i] <= {phase_default(i), OSP_DIV_RST};
      end
    end else if (nvm_load_i) begin
      pend_cond_reg <= nvm_cond_i;
      for (int i = 0; i < OSP_OUTPUTS; i++) begin
        pend_timing_reg[i] <= nvm_timing_i[i*OSP_TIMING_W +: OSP_TIMING_W];
      end
    end else if (cmd_hit && cmd_write_i) begin
      if (cmd_code_i == OSP_CMD_COND_SETUP) begin
        pend_cond_reg[pg_idx] <= cmd_wdata_i[OSP_CCM_BIT];
      end
      if (cmd_code_i == OSP_CMD_TIMING_SETUP) begin
        pend_timing_reg[pg_idx] <= cmd_wdata_i[OSP_TIMING_W-1:0];
      end
    end
  end

  // Active copy changes only on a storage reload, at every nvm_load_i pulse
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      act_cond_reg <= {OSP_OUTPUTS{OSP_CCM_RST}};
      for (int i = 0; i < OSP_OUTPUTS; i++) begin
        act_timing_reg[i] <= {phase_default(i), OSP_DIV_RST}; // [R17] [R15]
      end
    end else if (nvm_load_i) begin
      act_cond_reg <= nvm_cond_i; // [R14]
      for (int i = 0; i < OSP_OUTPUTS; i++) begin
        act_timing_reg[i] <= nvm_timing_i[i*OSP_TIMING_W +: OSP_TIMING_W]; // [R14]
      end
    end
  end

  // ==================================================================
  // Effective per-output settings, slaves following their master
  logic [OSP_OUTPUTS-1:0] start_hit;
  logic [OSP_OUTPUTS-1:0] stop_hit;
  logic [OSP_OUTPUTS-1:0] eff_ccm;
  logic [1:0] eff_div [OSP_OUTPUTS];
  logic [OSP_PHASE_OUT_W-1:0] eff_phase [OSP_OUTPUTS];
  logic [1:0] rank_cur_reg;

  genvar g;
  generate
    for (g = 0; g < OSP_OUTPUTS; g++) begin : g_out
      localparam int MST = g - (g % 2);
      logic slave;
      logic [1:0] sel;
      logic [4:0] mph;
      assign slave = (g % 2 == 1) && shr_sync_reg[g/2]; // [R12]
      assign sel = slave ? 2'(MST) : 2'(g);
      assign start_hit[g] = rank_field(rank_reg[sel], OSP_START_LSB) == rank_cur_reg; // [R06]
      assign stop_hit[g] = rank_field(rank_reg[sel], OSP_STOP_LSB) == rank_cur_reg; // [R06]
      assign eff_ccm[g] = act_cond_reg[sel]; // [R10] [R12]
      assign eff_div[g] = act_timing_reg[sel][OSP_DIV_LSB +: 2]; // [R15]
      assign mph = act_timing_reg[sel][OSP_PHASE_LSB +: 5]; // [R16]
      // Half period = two quarter units per divided clock, so shift by the divider code
      assign eff_phase[g] = slave ? 6'({1'b0, mph} + (OSP_HALF_BASE << eff_div[g]))
                                  : {1'b0, mph}; // [R13]
    end
  endgenerate

  // Registered configuration outputs for the switching stages
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ccm_o <= '0;
      clk_div_o <= '0;
      phase_o <= '0;
    end else begin
      for (int i = 0; i < OSP_OUTPUTS; i++) begin
        ccm_o[i] <= eff_ccm[i];
        clk_div_o[i*2 +: 2] <= eff_div[i];
        phase_o[i*OSP_PHASE_OUT_W +: OSP_PHASE_OUT_W] <= eff_phase[i];
      end
    end
  end

  assign store_cond_o = pend_cond_reg;
  generate
    for (g = 0; g < OSP_OUTPUTS; g++) begin : g_store
      assign store_timing_o[g*OSP_TIMING_W +: OSP_TIMING_W] = pend_timing_reg[g];
    end
  endgenerate

  // ==================================================================
  // Command answers, one cycle after the request
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_ack_o <= 1'b0;
      cmd_err_o <= 1'b0;
      cmd_rdata_o <= 8'h00;
    end else begin
      cmd_ack_o <= cmd_valid_i;
      cmd_err_o <= cmd_valid_i && !cmd_hit;
      cmd_rdata_o <= 8'h00;
      if (cmd_hit && !cmd_write_i) begin
        case (cmd_code_i)
          OSP_CMD_SEQ_SETUP: cmd_rdata_o <= {7'h00, wait_ignore_reg}; // [R02]
          OSP_CMD_SEQ_RANK: cmd_rdata_o <= {4'h0, rank_reg[pg_idx]}; // [R05]
          // Share flag only from even pages; slaves report zero
          OSP_CMD_COND_SETUP: cmd_rdata_o <= {6'h00,
            !pg_idx[0] && shr_sync_reg[pg_idx[1]], act_cond_reg[pg_idx]}; // [R11] [R10]
          OSP_CMD_TIMING_SETUP: cmd_rdata_o <= {1'b0, act_timing_reg[pg_idx]}; // [R16]
          default: cmd_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ==================================================================
  // Start and stop sequencer
  osp_state_e state_reg;
  logic [OSP_OUTPUTS-1:0] out_en_reg;
  logic rank_good;
  logic step_ok;

  // All outputs of the current rank good; a rank with no outputs passes at once
  assign rank_good = &(pg_sync_reg | ~start_hit);
  assign step_ok = wait_ignore_reg || rank_good; // [R01] [R18]

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= OSP_ST_IDLE;
      rank_cur_reg <= OSP_RANK_FIRST;
    end else begin
      case (state_reg)
        OSP_ST_IDLE: begin
          rank_cur_reg <= OSP_RANK_FIRST;
          if (seq_on_i) begin
            state_reg <= OSP_ST_START;
          end
        end
        OSP_ST_START: begin
          if (!seq_on_i) begin
            state_reg <= OSP_ST_STOP;
            rank_cur_reg <= OSP_RANK_FIRST;
          end else if ((out_en_reg & start_hit) == start_hit && step_ok) begin // [R18]
            if (rank_cur_reg == OSP_RANK_LAST) begin
              state_reg <= OSP_ST_ON;
            end
            rank_cur_reg <= rank_cur_reg + 2'h1;
          end
        end
        OSP_ST_ON: begin
          rank_cur_reg <= OSP_RANK_FIRST;
          if (!seq_on_i) begin
            state_reg <= OSP_ST_STOP;
          end
        end
        OSP_ST_STOP: begin
          // Turn-off finishes every step even if turn-on is asked again
          if (rank_cur_reg == OSP_RANK_LAST) begin
            state_reg <= OSP_ST_IDLE;
          end
          rank_cur_reg <= rank_cur_reg + 2'h1; // [R18]
        end
        default: begin
          state_reg <= OSP_ST_IDLE;
          rank_cur_reg <= OSP_RANK_FIRST;
        end
      endcase
    end
  end

  // Enables: a whole rank switches in one cycle
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_en_reg <= '0;
    end else if (state_reg == OSP_ST_START && seq_on_i) begin
      out_en_reg <= out_en_reg | start_hit; // [R06] [R03]
    end else if (state_reg == OSP_ST_STOP) begin
      out_en_reg <= out_en_reg & ~stop_hit; // [R06]
    end
  end

  assign out_enable_o = out_en_reg;
  assign seq_busy_o = (state_reg == OSP_ST_START) || (state_reg == OSP_ST_STOP);

  // ==================================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  AST_SETUP_HIGH_ZERO: assert property ( // [R02]
    cmd_hit && !cmd_write_i && cmd_code_i == OSP_CMD_SEQ_SETUP |=> cmd_rdata_o[7:1] == 7'h00)
    else $error("setup byte upper bits not zero");
  AST_FIRST_RANK_AT_ONCE: assert property ( // [R03]
    state_reg == OSP_ST_START && seq_on_i && rank_cur_reg == OSP_RANK_FIRST
      |=> (out_en_reg & $past(start_hit)) == $past(start_hit))
    else $error("first rank not enabled at once");
  AST_WAIT_PRIOR_GOOD: assert property ( // [R01]
    state_reg == OSP_ST_START && seq_on_i && !wait_ignore_reg && !rank_good
      |=> $stable(rank_cur_reg))
    else $error("rank advanced before power good");
  AST_STOP_TOGETHER: assert property ( // [R06]
    state_reg == OSP_ST_STOP |=> (out_en_reg & $past(stop_hit)) == '0)
    else $error("stop rank not cleared together");
  AST_BAD_PAGE_ERR: assert property ( // [R09]
    cmd_valid_i && cmd_code_i != OSP_CMD_SEQ_SETUP && cmd_page_i > OSP_PAGE_LAST
      |=> cmd_err_o && cmd_ack_o)
    else $error("out of range page not refused");
  AST_ACTIVE_HOLD: assert property ( // [R14]
    !nvm_load_i |=> $stable(act_cond_reg) && $stable(act_timing_reg[0]))
    else $error("active setting changed without reload");
  AST_SLAVE_FLAG_ZERO: assert property ( // [R11]
    cmd_valid_i && !cmd_write_i && cmd_code_i == OSP_CMD_COND_SETUP && cmd_page_i[0]
      |=> !cmd_rdata_o[OSP_SHARE_BIT])
    else $error("share flag seen on slave page");
  AST_SLAVE_HALF_PERIOD: assert property ( // [R13]
    shr_sync_reg[0] && $past(shr_sync_reg[0]) && $stable(act_timing_reg[0])
      |-> phase_o[11:6] == 6'(phase_o[5:0] + (OSP_HALF_BASE << clk_div_o[1:0])))
    else $error("slave phase not half period behind");
  AST_SEQ_STEPS: assert property ( // [R18]
    state_reg == OSP_ST_STOP && rank_cur_reg == OSP_RANK_FIRST |-> ##3 state_reg == OSP_ST_STOP
      ##1 state_reg == OSP_ST_IDLE && out_en_reg == '0)
    else $error("stop sequence not four steps");

  COV_START_DONE: cover property (state_reg == OSP_ST_START ##1 state_reg == OSP_ST_ON);
  COV_STOP_DONE: cover property (state_reg == OSP_ST_STOP ##1 state_reg == OSP_ST_IDLE);
  COV_SHARED_READ: cover property (cmd_hit && cmd_code_i == OSP_CMD_COND_SETUP && shr_sync_reg[0]);
  COV_WAITING: cover property (state_reg == OSP_ST_START && !rank_good && !wait_ignore_reg);
endmodule

// >>> shared/osp_pkg.sv
// Package for the output sequencing and phase configuration block.
// Assumes one 20 MHz clock; all constants used by the block live here.
package osp_pkg;
  // ==================================================================
  // Command codes
  localparam logic [7:0] OSP_CMD_SEQ_SETUP = 8'hD4;
  localparam logic [7:0] OSP_CMD_SEQ_RANK = 8'hD5;
  localparam logic [7:0] OSP_CMD_COND_SETUP = 8'hD6;
  localparam logic [7:0] OSP_CMD_TIMING_SETUP = 8'hD7;
  // ==================================================================
  // Pages and ranks
  localparam int OSP_OUTPUTS = 4;
  localparam logic [7:0] OSP_PAGE_LAST = 8'h03;
  localparam logic [1:0] OSP_RANK_FIRST = 2'h0;
  localparam logic [1:0] OSP_RANK_LAST = 2'h3;
  // ==================================================================
  // Field positions
  localparam int OSP_WAIT_BIT = 0;
  localparam int OSP_START_LSB = 0;
  localparam int OSP_STOP_LSB = 2;
  localparam int OSP_RANK_W = 4;
  localparam int OSP_CCM_BIT = 0;
  localparam int OSP_SHARE_BIT = 1;
  localparam int OSP_DIV_LSB = 0;
  localparam int OSP_PHASE_LSB = 2;
  localparam int OSP_TIMING_W = 7;
  localparam int OSP_PHASE_OUT_W = 6;
  // ==================================================================
  // Reset values
  localparam logic OSP_WAIT_RST = 1'h0;
  localparam logic [3:0] OSP_RANK_RST = 4'h0;
  localparam logic OSP_CCM_RST = 1'h0;
  localparam logic [1:0] OSP_DIV_RST = 2'h0;
  localparam logic [4:0] OSP_PHASE_RST0 = 5'h00;
  localparam logic [4:0] OSP_PHASE_RST1 = 5'h02;
  localparam logic [4:0] OSP_PHASE_RST2 = 5'h01;
  localparam logic [4:0] OSP_PHASE_RST3 = 5'h03;
  // Half switching period in quarter-oscillator units is this shifted by the divider code
  localparam logic [5:0] OSP_HALF_BASE = 6'h02;
  // ==================================================================
  // Sequencer states
  typedef enum logic [3:0] {
    OSP_ST_IDLE = 4'h1,
    OSP_ST_START = 4'h2,
    OSP_ST_ON = 4'h4,
    OSP_ST_STOP = 4'h8
  } osp_state_e;
endpackage
